// file: rtl/lrc_pkg.sv
/*
  Shared constants and types for the LFSR random and CRC16 engine and its controller.
  Assumes both ends are built from this package and run on one system clock.
*/
package lrc_pkg;

  // ************************************************************
  // lfsr shape
  // ************************************************************
  localparam int unsigned LFSR_W = 16;
  localparam logic [15:0] LFSR_RST = 16'hFFFF;
  // x^15, x^2 and x^0 terms of x^16 + x^15 + x^2 + 1
  localparam logic [15:0] POLY_TAPS = 16'h8005;
  localparam int unsigned RND_SHIFTS = 13;
  localparam int unsigned CRC_SHIFTS = 8;

  // ************************************************************
  // device register map on the link
  // ************************************************************
  localparam logic [7:0] ADDR_CTL_ONE = 8'hB4;
  localparam logic [7:0] ADDR_SEED_LOW = 8'hBC;
  localparam logic [7:0] ADDR_CRC_HIGH = 8'hBD;
  localparam int unsigned STEP_LSB = 2;
  localparam int unsigned STEP_MSB = 3;
  localparam logic [3:0] CTL_HI_RST = 4'h3;
  localparam logic [1:0] CTL_LO_RST = 2'h3;

  typedef enum logic [1:0] {
    STEP_RUN = 2'b00,
    STEP_ONCE = 2'b01,
    STEP_RSVD = 2'b10,
    STEP_OFF = 2'b11
  } lrc_step_t;

  // ************************************************************
  // controller software port
  // ************************************************************
  localparam logic [3:0] SW_SEED = 4'h0;
  localparam logic [3:0] SW_CRC = 4'h1;
  localparam logic [3:0] SW_CTL = 4'h2;
  localparam logic [3:0] SW_RND = 4'h3;
  localparam logic [3:0] SW_STAT = 4'h4;
  localparam logic [3:0] SW_HCTL = 4'h5;
  localparam logic HCTL_RST = 1'b0;

  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 16;

endpackage : lrc_pkg

// file: rtl/lrc_if.sv
/*
  Link between the random/CRC engine and its controller (register bus plus strobe-processor port).
  Assumes both ends share clk_sys; the testbench instantiates it and joins the two ends.
*/
`timescale 1ns/10ps
interface lrc_if;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic rnd_req;
  logic [7:0] rnd_byte;

  modport dev (
    input reg_wr,
    input reg_rd,
    input reg_addr,
    input reg_wdata,
    output reg_rdata,
    input rnd_req,
    output rnd_byte
  );

  modport host (
    output reg_wr,
    output reg_rd,
    output reg_addr,
    output reg_wdata,
    input reg_rdata,
    output rnd_req,
    input rnd_byte
  );
endinterface : lrc_if

// file: rtl/lrc_dev.sv
/*
  Device end: 16-bit LFSR random generator and CRC16 engine with its three registers.
  Assumes the controller drives one-cycle strobes on the link, synchronous to clk_sys.
*/
// Notes on behaviour
// [RQ1] 16-bit LFSR, polynomial x16+x15+x2+1
// [RQ2] step field 11 stops all stepping
// [RQ3] high and low registers read LFSR halves
// [RQ4] field 00: step per strobe-processor read
// [RQ5] fresh random byte at LSB end
// [RQ6] bytes go to CPU and strobe processor
// [RQ7] field 01 steps once, then clears
// [RQ8] low write: low byte up, data in
// [RQ9] software seeds with two low writes
// [RQ10] seeds 0x0000, 0x8003 stay fixed
// [RQ11] software seeds from radio random bits
// [RQ12] high write: CRC byte, MSB first
// [RQ13] one CRC byte accepted every clock
// [RQ14] seed before CRC, 0x0000 or 0xFFFF
// [RQ15] step field bits 3:2, 10 reserved
// [RQ16] unrolled step equals single shifts
`timescale 1ns/10ps
module lrc_dev (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  lrc_if.dev link,
  output logic [15:0] lfsr_value,
  output lrc_pkg::lrc_step_t step_mode
);

  // ************************************************************
  // shift functions
  // ************************************************************
  // galois form: with no input, 0x0000 and 0x8003 map onto themselves
  function automatic logic [15:0] lrc_shift1(input logic [15:0] v, input logic din);
    logic fb;
    fb = v[15] ^ din;
    lrc_shift1 = {v[14:0], 1'b0} ^ (fb ? lrc_pkg::POLY_TAPS : 16'h0000); // [RQ1] [RQ10]
  endfunction : lrc_shift1

  function automatic logic [15:0] lrc_rnd_step(input logic [15:0] v);
    logic [15:0] t;
    t = v;
    for (int i = 0; i < lrc_pkg::RND_SHIFTS; i++) begin
      t = lrc_shift1(t, 1'b0); // [RQ16]
    end
    lrc_rnd_step = t;
  endfunction : lrc_rnd_step

  function automatic logic [15:0] lrc_crc_byte(input logic [15:0] v, input logic [7:0] d);
    logic [15:0] t;
    t = v;
    for (int i = lrc_pkg::CRC_SHIFTS - 1; i >= 0; i--) begin
      t = lrc_shift1(t, d[i]); // [RQ12] [RQ16]
    end
    lrc_crc_byte = t;
  endfunction : lrc_crc_byte

  // ************************************************************
  // decode
  // ************************************************************
  logic [15:0] lfsr_ff;
  lrc_pkg::lrc_step_t step_ff;
  logic [3:0] ctl_hi_ff;
  logic [1:0] ctl_lo_ff;
  logic [7:0] rdata_ff;
  logic wr_seed;
  logic wr_crc;
  logic wr_ctl;
  logic do_step;

  assign wr_seed = ce && link.reg_wr && (link.reg_addr == lrc_pkg::ADDR_SEED_LOW);
  assign wr_crc = ce && link.reg_wr && (link.reg_addr == lrc_pkg::ADDR_CRC_HIGH);
  assign wr_ctl = ce && link.reg_wr && (link.reg_addr == lrc_pkg::ADDR_CTL_ONE);

  always_comb begin
    unique case (step_ff)
      lrc_pkg::STEP_RUN: do_step = ce && link.rnd_req; // [RQ4]
      lrc_pkg::STEP_ONCE: do_step = ce; // [RQ7]
      lrc_pkg::STEP_RSVD: do_step = 1'b0; // [RQ15]
      lrc_pkg::STEP_OFF: do_step = 1'b0; // [RQ2]
    endcase
  end

  // ************************************************************
  // lfsr
  // ************************************************************
  // seed write beats a crc write beats a step; only one write per cycle anyway
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr_ff <= lrc_pkg::LFSR_RST;
    end else if (wr_seed) begin
      lfsr_ff <= {lfsr_ff[7:0], link.reg_wdata}; // [RQ8] [RQ9]
    end else if (wr_crc) begin
      lfsr_ff <= lrc_crc_byte(lfsr_ff, link.reg_wdata); // [RQ12] [RQ13]
    end else if (do_step) begin
      lfsr_ff <= lrc_rnd_step(lfsr_ff); // [RQ4] [RQ5] [RQ7]
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  // a software write in the clear cycle wins, so a fresh 01 is never lost
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      step_ff <= lrc_pkg::STEP_RUN;
      ctl_hi_ff <= lrc_pkg::CTL_HI_RST;
      ctl_lo_ff <= lrc_pkg::CTL_LO_RST;
    end else if (wr_ctl) begin
      ctl_hi_ff <= link.reg_wdata[7:4];
      step_ff <= lrc_pkg::lrc_step_t'(link.reg_wdata[lrc_pkg::STEP_MSB:lrc_pkg::STEP_LSB]); // [RQ15]
      ctl_lo_ff <= link.reg_wdata[1:0];
    end else if (ce && step_ff == lrc_pkg::STEP_ONCE) begin
      step_ff <= lrc_pkg::STEP_RUN; // [RQ7]
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (ce && link.reg_rd) begin
      unique case (link.reg_addr)
        lrc_pkg::ADDR_SEED_LOW: rdata_ff <= lfsr_ff[7:0]; // [RQ3] [RQ6]
        lrc_pkg::ADDR_CRC_HIGH: rdata_ff <= lfsr_ff[15:8]; // [RQ3]
        lrc_pkg::ADDR_CTL_ONE: rdata_ff <= {ctl_hi_ff, step_ff, ctl_lo_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign link.reg_rdata = rdata_ff;
  // the strobe processor samples this byte in the cycle of its request
  assign link.rnd_byte = lfsr_ff[7:0]; // [RQ5] [RQ6]
  assign lfsr_value = lfsr_ff;
  assign step_mode = step_ff;

endmodule : lrc_dev

// file: rtl/lrc_host.sv
/*
  Controller end: software register port, strobe-processor random reads and a CRC byte FIFO
  drained onto the engine's high data register. Assumes one clock and synchronous inputs.
*/
`timescale 1ns/10ps
module lrc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(D):0] count
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_ready && out_valid;
  assign out_data = mem_ff[rp_ff];
  assign count = cnt_ff;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : lrc_fifo

module lrc_host (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  input wire logic crc_in_valid,
  input wire logic [7:0] crc_in_data,
  output logic crc_in_ready,
  lrc_if.host link
);

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic [7:0] lrc_map_addr(input logic [3:0] a);
    unique case (a)
      lrc_pkg::SW_SEED: lrc_map_addr = lrc_pkg::ADDR_SEED_LOW;
      lrc_pkg::SW_CRC: lrc_map_addr = lrc_pkg::ADDR_CRC_HIGH;
      default: lrc_map_addr = lrc_pkg::ADDR_CTL_ONE;
    endcase
  endfunction : lrc_map_addr

  logic sw_dev;
  logic sw_busy;
  logic drain;
  logic crc_run_ff;
  logic fwd_ff;
  logic [7:0] loc_rdata_ff;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [4:0] fifo_count;

  assign sw_dev = (sw_addr <= lrc_pkg::SW_CTL);
  assign sw_busy = ce && sw_dev && (sw_wr || sw_rd);
  // software access owns the link; the fifo also stalls for a random read so no step is lost
  assign drain = ce && crc_run_ff && fifo_valid && !sw_busy && !(sw_rd && sw_addr == lrc_pkg::SW_RND); // [RQ4]

  lrc_fifo #(
    .W(lrc_pkg::FIFO_W),
    .D(lrc_pkg::FIFO_D)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .in_valid(crc_in_valid),
    .in_data(crc_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(drain),
    .count(fifo_count)
  );

  assign crc_in_ready = ce && fifo_in_ready;

  // ************************************************************
  // link drive
  // ************************************************************
  // seeding and ctl writes pass straight through from software
  always_comb begin
    link.reg_wr = 1'b0;
    link.reg_rd = 1'b0;
    link.reg_addr = 8'h00;
    link.reg_wdata = 8'h00;
    if (sw_busy) begin
      link.reg_wr = sw_wr; // [RQ9] [RQ14]
      link.reg_rd = sw_rd;
      link.reg_addr = lrc_map_addr(sw_addr);
      link.reg_wdata = sw_wdata;
    end else if (drain) begin
      link.reg_wr = 1'b1; // [RQ13]
      link.reg_addr = lrc_pkg::ADDR_CRC_HIGH;
      link.reg_wdata = fifo_data;
    end
  end

  assign link.rnd_req = ce && sw_rd && (sw_addr == lrc_pkg::SW_RND); // [RQ4] [RQ6]

  // ************************************************************
  // own registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      crc_run_ff <= lrc_pkg::HCTL_RST;
    end else if (ce && sw_wr && sw_addr == lrc_pkg::SW_HCTL) begin
      crc_run_ff <= sw_wdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fwd_ff <= 1'b0;
      loc_rdata_ff <= 8'h00;
    end else if (ce) begin
      fwd_ff <= sw_rd && sw_dev;
      if (sw_rd) begin
        unique case (sw_addr)
          lrc_pkg::SW_RND: loc_rdata_ff <= link.rnd_byte;
          lrc_pkg::SW_STAT: loc_rdata_ff <= {!fifo_in_ready, !fifo_valid, 1'b0, fifo_count};
          lrc_pkg::SW_HCTL: loc_rdata_ff <= {7'h00, crc_run_ff};
          default: loc_rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // engine data is already a flop one cycle after its read strobe
  assign sw_rdata = fwd_ff ? link.reg_rdata : loc_rdata_ff;

endmodule : lrc_host

// file: verif/lrc_ref_pkg.sv
/*
  Reference LFSR shift for the bench side, independent of the design code.
  Assumes Galois form, shift left, taps from x^16 + x^15 + x^2 + 1.
*/
package lrc_ref_pkg;

  // ************************************************************
  // reference shift
  // ************************************************************
  // n of 8 feeds d msb first; any other n shifts with zero input
  function automatic logic [15:0] shf(input logic [15:0] v, input logic [7:0] d, input int n);
    logic f;
    for (int i = 0; i < n; i++) begin
      f = v[15] ^ (n == 8 && d[7 - i]);
      v = {v[14:0], 1'b0} ^ (f ? 16'h8005 : 16'h0000);
    end
    return v;
  endfunction : shf

endpackage : lrc_ref_pkg

// file: verif/lrc_assertions.sv
/*
  Concurrent checks on the link between the two ends and on the engine state.
  Assumes instantiation in testbench beside the link interface, one clock domain.
*/
`timescale 1ns/10ps
module lrc_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic rnd_req,
  input wire logic [7:0] rnd_byte,
  input wire logic [15:0] lfsr_value,
  input var lrc_pkg::lrc_step_t step_mode
);
  // ************************************************************
  // helpers
  // ************************************************************
  logic [7:0] lfsr_hi;
  logic [1:0] wd_fld;
  assign lfsr_hi = lfsr_value[15:8];
  assign wd_fld = reg_wdata[3:2];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ************************************************************
  // checks
  // ************************************************************
  AST_SEED_SHIFT: assert property (
    ce && reg_wr && reg_addr == 8'hBC |=> lfsr_hi == $past(rnd_byte) && rnd_byte == $past(reg_wdata))
    else $error("seed write shift wrong");
  AST_CRC_BYTE: assert property (
    ce && reg_wr && reg_addr == 8'hBD |=> lfsr_value == lrc_ref_pkg::shf($past(lfsr_value), $past(reg_wdata), 8))
    else $error("crc byte update wrong");
  AST_RUN_STEP: assert property (
    ce && rnd_req && !reg_wr && step_mode == 2'b00 |=> lfsr_value == lrc_ref_pkg::shf($past(lfsr_value), 8'h00, 13))
    else $error("random read step wrong");
  AST_ONCE_STEP: assert property (
    ce && !reg_wr && step_mode == 2'b01
    |=> step_mode == 2'b00 && lfsr_value == lrc_ref_pkg::shf($past(lfsr_value), 8'h00, 13))
    else $error("single step wrong");
  AST_OFF_HOLD: assert property (
    !reg_wr && step_mode == 2'b11 |=> $stable(lfsr_value))
    else $error("stopped engine moved");
  AST_RSVD_HOLD: assert property (
    (!reg_wr && step_mode == 2'b10) [*2] |-> $stable(lfsr_value))
    else $error("reserved mode moved");
  AST_FIELD_POS: assert property (
    ce && reg_wr && reg_addr == 8'hB4 |=> step_mode == $past(wd_fld))
    else $error("step field not bits 3:2");
  AST_HI_READ: assert property (
    ce && reg_rd && reg_addr == 8'hBD |=> reg_rdata == $past(lfsr_hi))
    else $error("high read wrong");
  AST_LO_READ: assert property (
    ce && reg_rd && reg_addr == 8'hBC |=> reg_rdata == $past(rnd_byte))
    else $error("low read wrong");
  AST_RND_TAP: assert property (
    ce && rnd_req && !reg_wr && step_mode == 2'b00
    |=> {lfsr_hi, rnd_byte} == lrc_ref_pkg::shf($past(lfsr_value), 8'h00, 13))
    else $error("random byte not fresh lsb end");
endmodule : lrc_assertions

// file: verif/testbench.sv
/*
  Self-checking bench joining the engine and its controller through the link.
  Assumes the two design ends and the reference package are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rstn, ce, sw_wr, sw_rd, crc_in_valid, crc_in_ready;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, crc_in_data, b;
  logic [15:0] lfsr_value, m;
  lrc_pkg::lrc_step_t step_mode;
  logic [31:0] rs;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int num_errors, n_checks;
  lrc_if lnk();
  lrc_dev lrc_dev_inst (.clk_sys, .rstn, .ce, .link(lnk), .lfsr_value, .step_mode);
  lrc_host lrc_host_inst (.clk_sys, .rstn, .ce, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
    .crc_in_valid, .crc_in_data, .crc_in_ready, .link(lnk));
  lrc_assertions lrc_assertions_inst (.clk_sys, .rstn, .ce, .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .rnd_req(lnk.rnd_req),
    .rnd_byte(lnk.rnd_byte), .lfsr_value, .step_mode);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] rnd8();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd8
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // strobes stay up until the next call, so calls run back to back
  task automatic sw_op(input logic wr, input logic rd, input logic [3:0] a, input logic [7:0] d);
    sw_wr <= wr;
    sw_rd <= rd;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk_sys);
  endtask : sw_op
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sw_op(1'b0, 1'b1, a, 8'h00);
  endtask : rd_chk
  task automatic idle();
    sw_op(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : idle
  task automatic seed(input logic [15:0] s);
    sw_op(1'b1, 1'b0, 4'h0, s[15:8]);
    sw_op(1'b1, 1'b0, 4'h0, s[7:0]);
    m = s;
  endtask : seed
  task automatic rd_both();
    rd_chk(4'h1, m[15:8]);
    rd_chk(4'h0, m[7:0]);
  endtask : rd_both
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // ************************************************************
  // clock and read monitor
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // engine read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= sw_rd && ce;
    if (rd_d === 1'b1) begin
      chk({8'h00, sw_rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rstn, sw_wr, sw_rd, crc_in_valid} = 4'h0;
    ce = 1'b1;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    crc_in_data = 8'h00;
    rs = 32'h8;
    num_errors = 0;
    n_checks = 0;
    m = 16'hFFFF;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd_chk(4'h2, 8'h33);
    rd_both();
    rd_chk(4'h4, 8'h40);
    rd_chk(4'hF, 8'h00);
    seed({rnd8(), rnd8()});
    rd_both();
    ce <= 1'b0;
    sw_op(1'b1, 1'b0, 4'h0, 8'h5A);
    ce <= 1'b1;
    rd_both();
    for (int k = 0; k < 4; k++) begin
      rd_chk(4'h3, m[7:0]);
      m = lrc_ref_pkg::shf(m, 8'h00, 13);
    end
    rd_both();
    sw_op(1'b1, 1'b0, 4'h2, 8'h37);
    idle();
    m = lrc_ref_pkg::shf(m, 8'h00, 13);
    rd_chk(4'h2, 8'h33);
    rd_both();
    for (int k = 0; k < 2; k++) begin
      b = (k == 0) ? 8'h3F : 8'h3B;
      sw_op(1'b1, 1'b0, 4'h2, b);
      rd_chk(4'h3, m[7:0]);
      rd_chk(4'h3, m[7:0]);
      rd_chk(4'h2, b);
      rd_both();
    end
    sw_op(1'b1, 1'b0, 4'h2, 8'h33);
    for (int k = 0; k < 2; k++) begin
      seed((k == 0) ? 16'h0000 : 16'h8003);
      sw_op(1'b1, 1'b0, 4'h2, 8'h37);
      idle();
      rd_both();
    end
    seed(16'hFFFF);
    idle();
    // drain is off, so the buffer fills and then refuses
    for (int k = 0; k < 17; k++) begin
      b = rnd8();
      crc_in_valid <= 1'b1;
      crc_in_data <= b;
      @(posedge clk_sys);
      chk({15'h0000, crc_in_ready}, (k < 16) ? 16'h0001 : 16'h0000);
      if (k < 16) m = lrc_ref_pkg::shf(m, b, 8);
    end
    crc_in_valid <= 1'b0;
    rd_chk(4'h4, 8'h90);
    sw_op(1'b1, 1'b0, 4'h5, 8'h01);
    // control reads own the link and stall the drain; byte order must survive
    rd_chk(4'h2, 8'h33);
    rd_chk(4'h2, 8'h33);
    idle();
    repeat (18) @(posedge clk_sys);
    rd_chk(4'h4, 8'h40);
    rd_chk(4'h5, 8'h01);
    rd_both();
    b = rnd8();
    sw_op(1'b1, 1'b0, 4'h1, b);
    m = lrc_ref_pkg::shf(m, b, 8);
    rd_both();
    // a reset in mid-run must bring back the ctl, host control and LFSR values after reset
    sw_op(1'b1, 1'b0, 4'h2, 8'h3F);
    idle();
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    m = 16'hFFFF;
    rd_chk(4'h2, 8'h33);
    rd_chk(4'h5, 8'h00);
    rd_both();
    idle();
    repeat (2) @(posedge clk_sys);
    close_out();
  end
endmodule : testbench
